// ==== rtl/dipc_capture.v ====
// Parallel input pattern capture with AHB-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "dipc_defines.vh"
module dipc_capture #(
   parameter DEPTH_LOG2 = 10
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire [31:0] pin_i,
   output reg  [31:0] pin_o,
   output reg  [31:0] pin_oe_n,
   input  wire        strobe_i,
   output reg         busy
);
   localparam DEPTH = 1 << DEPTH_LOG2;

   wire [32:0]           sync_w;
   wire [31:0]           pins_w;
   wire                  strobe_w;
   reg                   strobe_prev_q;
   reg [31:0]            ctrl_q;
   reg [31:0]            psel_q;
   reg [31:0]            match_q;
   reg [31:0]            mask_q;
   reg [15:0]            count_q;
   reg [31:0]            drvout_q;
   reg [1:0]             state_q;
   reg [31:0]            pre_cnt_q;
   reg [15:0]            post_cnt_q;
   reg [31:0]            live_q;
   reg [31:0]            mem [0:DEPTH-1];
   reg [DEPTH_LOG2-1:0]  wr_ptr_q;
   reg [DEPTH_LOG2-1:0]  rd_ptr_q;
   reg                   ap_valid_q;
   reg                   ap_write_q;
   reg [11:0]            ap_addr_q;
   reg [31:0]            sample_q;
   reg                   sample_vld_q;
   reg                   hit_w_q;
   reg [1:0]             state_d;
   reg [31:0]            pre_cnt_d;
   reg [15:0]            post_cnt_d;
   reg [DEPTH_LOG2-1:0]  wr_ptr_d;
   reg [31:0]            live_d;
   reg                   mem_we_d;
   reg [31:0]            rdata_d;
   wire [1:0]            mode_w;
   wire [31:0]           in_en_w;
   wire [31:0]           word_w;
   wire                  hit_w;
   wire                  strobe_rise_w;
   wire                  take_w;
   wire                  go_w;
   wire                  abort_w;
   wire                  data_rd_w;
   wire                  ap_take_w;
   wire                  wr_en_w;
   wire [31:0]           miss_w;
   genvar                b;

   // Pins and strobe enter through the synchroniser
   // Three flops plus agreement: about four cycles from pin to word
   dipc_pin_sync #(
      .WIDTH (33)
   ) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .async_i ({strobe_i, pin_i}),
      .sync_q  (sync_w)
   );

   assign strobe_w      = sync_w[32];
   assign mode_w        = ctrl_q[`DIPC_CTRL_MODE_MSB:`DIPC_CTRL_MODE_LSB];
   // Rising edge of the filtered strobe
   assign strobe_rise_w = strobe_w & ~strobe_prev_q;

   // Per pin: the pad sees the AND of driver and outside source, then enable and mask
   generate
      for (b = 0; b < 32; b = b + 1)
      begin : g_pin
         assign pins_w[b]  = sync_w[b] & drvout_q[b];
         assign in_en_w[b] = ctrl_q[`DIPC_CTRL_ALLEN] | psel_q[b];
         assign word_w[b]  = pins_w[b] & in_en_w[b];
         assign miss_w[b]  = (word_w[b] ^ match_q[b]) & mask_q[b];
      end
   endgenerate
   // All compared bits equal: a match
   assign hit_w = (miss_w == 32'h0000_0000);

   // Bus address phase capture, held for the data phase that follows
   assign ap_take_w = hsel & hready & htrans[1];
   assign wr_en_w   = ap_valid_q & ap_write_q;
   assign go_w      = wr_en_w & (ap_addr_q == `DIPC_START_OFS) & hwdata[`DIPC_START_GO];
   assign abort_w   = wr_en_w & (ap_addr_q == `DIPC_START_OFS) & hwdata[`DIPC_START_ABORT];
   // Readout steps at the address phase so back-to-back reads walk on
   assign data_rd_w = ap_take_w & ~hwrite & (haddr[11:0] == `DIPC_DATA_OFS);

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q  <= 12'h000;
      end
      else
      begin
         ap_valid_q <= ap_take_w;
         ap_write_q <= hwrite;
         ap_addr_q  <= haddr[11:0];
      end
   end

   // Software registers; a write lands at the end of its data phase
   // Writes to unmapped offsets are dropped
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q   <= `DIPC_CTRL_RST;
         psel_q   <= `DIPC_PSEL_RST;
         match_q  <= `DIPC_MATCH_RST;
         mask_q   <= `DIPC_MASK_RST;
         count_q  <= `DIPC_COUNT_RST;
         drvout_q <= `DIPC_DRVOUT_RST;
      end
      else if (wr_en_w)
      begin
         case (ap_addr_q)
            `DIPC_CTRL_OFS:   ctrl_q   <= hwdata & 32'h0000_0007;
            `DIPC_PSEL_OFS:   psel_q   <= hwdata;
            `DIPC_MATCH_OFS:  match_q  <= hwdata;
            `DIPC_MASK_OFS:   mask_q   <= hwdata;
            `DIPC_COUNT_OFS:  count_q  <= hwdata[15:0];
            `DIPC_DRVOUT_OFS: drvout_q <= hwdata;
            default:          ctrl_q   <= ctrl_q;
         endcase
      end
   end

   // One registered sample per clock, or per strobe edge in handshake mode
   // Strobes must stay high and low a few cycles to pass the pin filter
   assign take_w = (mode_w == `DIPC_MODE_STROBE) ? strobe_rise_w : 1'b1;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         strobe_prev_q <= 1'b0;
         sample_q      <= 32'h0000_0000;
         sample_vld_q  <= 1'b0;
      end
      else
      begin
         strobe_prev_q <= strobe_w;
         sample_q      <= word_w;
         sample_vld_q  <= take_w;
      end
   end

   // Capture sequencer, next state
   always @*
   begin
      state_d    = state_q;
      pre_cnt_d  = pre_cnt_q;
      post_cnt_d = post_cnt_q;
      wr_ptr_d   = wr_ptr_q;
      live_d     = live_q;
      mem_we_d   = 1'b0;
      // Abort wins over a start written in the same beat
      if (abort_w)
         state_d = `DIPC_ST_DONE;
      else if (go_w)
      begin
         pre_cnt_d  = 32'h0000_0000;
         post_cnt_d = 16'h0000;
         wr_ptr_d   = {DEPTH_LOG2{1'b0}};
         if (mode_w == `DIPC_MODE_DIRECT)
         begin
            live_d  = word_w;
            state_d = `DIPC_ST_DONE;
         end
         // A zero count ends at once
         else if (count_q == 16'h0000)
            state_d = `DIPC_ST_DONE;
         else if (mode_w == `DIPC_MODE_PATTERN)
            state_d = `DIPC_ST_ARMED;
         else
            state_d = `DIPC_ST_CAPTURE;
      end
      else
      begin
         case (state_q)
            `DIPC_ST_ARMED:
            begin
               // The matching word itself is not stored
               if (sample_vld_q)
               begin
                  if (hit_w_q)
                     state_d = `DIPC_ST_CAPTURE;
                  else
                     pre_cnt_d = pre_cnt_q + 32'h0000_0001;
               end
            end
            `DIPC_ST_CAPTURE:
            begin
               if (sample_vld_q)
               begin
                  mem_we_d   = 1'b1;
                  wr_ptr_d   = wr_ptr_q + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
                  post_cnt_d = post_cnt_q + 16'h0001;
                  if (post_cnt_d == count_q)
                     state_d = `DIPC_ST_DONE;
               end
            end
            default: state_d = state_q;
         endcase
      end
   end

   // Sequencer registers
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q    <= `DIPC_ST_IDLE;
         pre_cnt_q  <= 32'h0000_0000;
         post_cnt_q <= 16'h0000;
         wr_ptr_q   <= {DEPTH_LOG2{1'b0}};
         live_q     <= 32'h0000_0000;
      end
      else
      begin
         state_q    <= state_d;
         pre_cnt_q  <= pre_cnt_d;
         post_cnt_q <= post_cnt_d;
         wr_ptr_q   <= wr_ptr_d;
         live_q     <= live_d;
      end
   end

   // Sample memory, written in capture order
   // No reset: only entries up to the stored count are meaningful
   always @(posedge hclk)
   begin
      if (mem_we_d)
         mem[wr_ptr_q] <= sample_q;
   end

   // Match result aligned with the registered sample
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hit_w_q <= 1'b0;
      else
         hit_w_q <= hit_w;
   end

   // Readout pointer walks oldest first
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rd_ptr_q <= {DEPTH_LOG2{1'b0}};
      else if (go_w)
         rd_ptr_q <= {DEPTH_LOG2{1'b0}};
      else if (data_rd_w)
         rd_ptr_q <= rd_ptr_q + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
   end

   // Read data select; unmapped offsets read as zero
   always @*
   begin
      rdata_d = 32'h0000_0000;
      case (haddr[11:0])
         `DIPC_CTRL_OFS:    rdata_d = ctrl_q;
         `DIPC_PSEL_OFS:    rdata_d = psel_q;
         `DIPC_MATCH_OFS:   rdata_d = match_q;
         `DIPC_MASK_OFS:    rdata_d = mask_q;
         `DIPC_COUNT_OFS:   rdata_d = {16'h0000, count_q};
         `DIPC_STATUS_OFS:  rdata_d = {30'h0000_0000, state_q};
         `DIPC_PRECNT_OFS:  rdata_d = pre_cnt_q;
         `DIPC_POSTCNT_OFS: rdata_d = {16'h0000, post_cnt_q};
         `DIPC_DATA_OFS:    rdata_d = mem[rd_ptr_q];
         `DIPC_LIVE_OFS:    rdata_d = live_q;
         `DIPC_DRVOUT_OFS:  rdata_d = drvout_q;
         default:           rdata_d = 32'h0000_0000;
      endcase
   end

   // Read data, registered for the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (ap_take_w && !hwrite)
         hrdata <= rdata_d;
   end

   // Output driver: open drain, enable low pulls the pin low
   // Bus answer is fixed: zero wait states, always OKAY
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         pin_o     <= 32'h0000_0000;
         pin_oe_n  <= 32'hFFFF_FFFF;
         busy      <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         pin_o     <= 32'h0000_0000;
         pin_oe_n  <= drvout_q;
         busy      <= (state_q == `DIPC_ST_ARMED) || (state_q == `DIPC_ST_CAPTURE);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/dipc_defines.vh ====
// Register map, field positions, reset values and constants of the pattern capture block
`ifndef DIPC_DEFINES_VH
`define DIPC_DEFINES_VH
`define DIPC_CTRL_OFS      12'h000
`define DIPC_START_OFS     12'h004
`define DIPC_PSEL_OFS      12'h008
`define DIPC_MATCH_OFS     12'h00C
`define DIPC_MASK_OFS      12'h010
`define DIPC_COUNT_OFS     12'h014
`define DIPC_STATUS_OFS    12'h018
`define DIPC_PRECNT_OFS    12'h01C
`define DIPC_POSTCNT_OFS   12'h020
`define DIPC_DATA_OFS      12'h024
`define DIPC_LIVE_OFS      12'h028
`define DIPC_DRVOUT_OFS    12'h02C
`define DIPC_CTRL_MODE_LSB 0
`define DIPC_CTRL_MODE_MSB 1
`define DIPC_CTRL_ALLEN    2
`define DIPC_MODE_NORMAL   2'b00
`define DIPC_MODE_PATTERN  2'b01
`define DIPC_MODE_STROBE   2'b10
`define DIPC_MODE_DIRECT   2'b11
`define DIPC_START_GO      0
`define DIPC_START_ABORT   1
`define DIPC_CTRL_RST      32'h0000_0004
`define DIPC_PSEL_RST      32'hFFFF_FFFF
`define DIPC_MATCH_RST     32'h0000_0000
`define DIPC_MASK_RST      32'h0000_0000
`define DIPC_COUNT_RST     16'h0001
`define DIPC_DRVOUT_RST    32'hFFFF_FFFF
`define DIPC_ST_IDLE       2'b00
`define DIPC_ST_ARMED      2'b01
`define DIPC_ST_CAPTURE    2'b10
`define DIPC_ST_DONE       2'b11
`endif

// ==== rtl/dipc_pin_sync.v ====
// Three-stage synchroniser with agreement filter for the shared pins and strobe
`timescale 1ns/1ps
`default_nettype none
module dipc_pin_sync #(
   parameter WIDTH = 33
) (
   input  wire             hclk,
   input  wire             hresetn,
   input  wire [WIDTH-1:0] async_i,
   output reg  [WIDTH-1:0] sync_q
);
   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   genvar          g;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_q <= {WIDTH{1'b0}};
         s2_q <= {WIDTH{1'b0}};
         s3_q <= {WIDTH{1'b0}};
      end
      else
      begin
         s1_q <= async_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts only once stages two and three agree
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : g_bit
         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               sync_q[g] <= 1'b0;
            else if (s2_q[g] == s3_q[g])
               sync_q[g] <= s3_q[g];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== testbench/dipc_capture_props.sv ====
// Checker for the pattern capture block ports
`timescale 1ns/1ps
`default_nettype none
`include "dipc_defines.vh"
module dipc_props #(
   parameter DEPTH_LOG2 = 10
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] pin_o,
   input wire logic [31:0] pin_oe_n,
   input wire logic        busy
);
   logic        w_q;
   logic [11:0] a_q;
   logic [31:0] d_q;
   logic        rd;
   assign rd = hsel && hready && htrans[1] && !hwrite;
   // Remember the data phase of each write
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         w_q <= 1'b0;
         a_q <= 12'h000;
         d_q <= 32'hFFFF_FFFF;
      end
      else
      begin
         w_q <= hsel && hready && htrans[1] && hwrite;
         a_q <= haddr[11:0];
         if (w_q && a_q == `DIPC_DRVOUT_OFS)
            d_q <= hwdata;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ready_high_a: assert property (hreadyout) else $error("wait state seen");
   resp_okay_a: assert property (!hresp) else $error("error response");
   pin_drive_a: assert property (pin_o == 32'h0000_0000) else $error("pin driven high");
   oe_reset_a: assert property (!$past(hresetn) |-> pin_oe_n == 32'hFFFF_FFFF) else $error("pin held low");
   idle_reset_a: assert property (!$past(hresetn) |-> !busy) else $error("busy after reset");
   drv_copy_a: assert property (w_q && a_q == `DIPC_DRVOUT_OFS |=> ##[0:1] pin_oe_n == d_q)
      else $error("driver not applied");
   abort_idle_a: assert property (w_q && a_q == `DIPC_START_OFS && hwdata[1] |-> ##[1:4] !busy)
      else $error("abort ignored");
   rdata_hold_a: assert property (!rd |=> $stable(hrdata)) else $error("read data moved");
   cover property (w_q && a_q == `DIPC_START_OFS && hwdata[0]);
   cover property ($fell(busy));
   cover property (rd && haddr[11:0] == `DIPC_DATA_OFS);
endmodule
bind dipc_capture dipc_props #(.DEPTH_LOG2(DEPTH_LOG2)) u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .busy(busy));
`default_nettype wire

// ==== testbench/dipc_ext_equip.sv ====
// Model of the equipment driving the shared pins and strobe
`timescale 1ns/1ps
`default_nettype none
module dipc_ext_equip (
   input  wire logic        hclk,
   input  wire logic [31:0] pin_oe_n,
   input  wire logic [31:0] pin_o,
   output wire logic [31:0] pin_i,
   output var  logic        strobe_i
);
   logic [31:0] level_q = 32'hFFFF_FFFF;
   initial strobe_i = 1'b0;
   // A pin reads low when either side pulls it low
   assign pin_i = level_q & (pin_oe_n | pin_o);
   task automatic put(input logic [31:0] w);
      @(posedge hclk);
      level_q <= w;
   endtask
   // Long enough to pass the pin filter
   task automatic strobe;
      repeat (6) @(posedge hclk);
      strobe_i <= 1'b1;
      repeat (6) @(posedge hclk);
      strobe_i <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== testbench/test_digital_input_pattern_capture.sv ====
// Self-checking bench for the pattern capture block
`timescale 1ns/1ps
`default_nettype none
`include "dipc_defines.vh"
module test_digital_input_pattern_capture;
   logic        hclk, hresetn, hsel, hwrite, busy, hresp, hreadyout, strobe_i;
   logic [31:0] haddr, hwdata, hrdata, pin_i, pin_o, pin_oe_n, rn, r, w, d, p;
   logic [1:0]  htrans;
   logic [31:0] q[$];
   int          n_mismatch, tests_run, cyc, k;
   initial
   begin
      hclk = 0;
      forever #12.5 hclk = ~hclk;
   end
   dipc_capture #(.DEPTH_LOG2(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .strobe_i(strobe_i), .busy(busy));
   dipc_ext_equip u_ext (.hclk(hclk), .pin_oe_n(pin_oe_n), .pin_o(pin_o), .pin_i(pin_i), .strobe_i(strobe_i));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= dat;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [11:0] a, input string s, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(s, r, e);
   endtask
   task automatic wait_idle;
      k = 0;
      repeat (3) @(negedge hclk);
      while (busy !== 1'b0 && k < 400)
      begin
         @(negedge hclk);
         k++;
      end
      chk("idle", {31'h0000_0000, busy}, 32'h0000_0000);
   endtask
   task automatic go;
      bus(1'b1, `DIPC_START_OFS, 32'h0000_0001);
      wait_idle;
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         report_and_stop;
      end
   end
   initial
   begin
      hresetn = 0;
      hsel = 0;
      haddr = 0;
      htrans = 0;
      hwrite = 0;
      hwdata = 0;
      rn = 32'h0001_1D85;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`DIPC_CTRL_OFS, "ctrl", 32'h0000_0004);
      rd(`DIPC_PSEL_OFS, "psel", 32'hFFFF_FFFF);
      rd(`DIPC_COUNT_OFS, "count", 32'h0000_0001);
      rd(`DIPC_DRVOUT_OFS, "drvout", 32'hFFFF_FFFF);
      rd(12'h030, "unmapped", 32'h0000_0000);
      repeat (3)
      begin
         w = lfsr(rn);
         d = lfsr(w);
         p = lfsr(d);
         rn = p;
         u_ext.put(w);
         bus(1'b1, `DIPC_DRVOUT_OFS, d);
         bus(1'b1, `DIPC_PSEL_OFS, p);
         bus(1'b1, `DIPC_CTRL_OFS, 32'h0000_0003);
         go;
         rd(`DIPC_LIVE_OFS, "live", w & d & p);
      end
      bus(1'b1, `DIPC_CTRL_OFS, 32'h0000_0007);
      go;
      rd(`DIPC_LIVE_OFS, "live all", w & d);
      bus(1'b1, `DIPC_DRVOUT_OFS, 32'hFFFF_FFFF);
      u_ext.put(rn);
      bus(1'b1, `DIPC_COUNT_OFS, 32'h0000_0002);
      bus(1'b1, `DIPC_CTRL_OFS, 32'h0000_0004);
      go;
      rd(`DIPC_POSTCNT_OFS, "normal n", 32'h0000_0002);
      repeat (2) rd(`DIPC_DATA_OFS, "normal", rn);
      bus(1'b1, `DIPC_COUNT_OFS, 32'h0000_0005);
      bus(1'b1, `DIPC_CTRL_OFS, 32'h0000_0006);
      bus(1'b1, `DIPC_START_OFS, 32'h0000_0001);
      repeat (5)
      begin
         rn = lfsr(rn);
         q.push_back(rn);
         u_ext.put(rn);
         u_ext.strobe;
      end
      wait_idle;
      u_ext.strobe;
      rd(`DIPC_POSTCNT_OFS, "strobe n", 32'h0000_0005);
      rd(`DIPC_STATUS_OFS, "done", 32'h0000_0003);
      repeat (5) rd(`DIPC_DATA_OFS, "strobe", q.pop_front());
      u_ext.put(32'hFFFF_7E39);
      bus(1'b1, `DIPC_MATCH_OFS, 32'h0000_7E38);
      bus(1'b1, `DIPC_MASK_OFS, 32'h0000_FFFF);
      bus(1'b1, `DIPC_COUNT_OFS, 32'h0000_0003);
      bus(1'b1, `DIPC_CTRL_OFS, 32'h0000_0005);
      bus(1'b1, `DIPC_START_OFS, 32'h0000_0001);
      repeat (20) @(negedge hclk);
      rd(`DIPC_STATUS_OFS, "armed", 32'h0000_0001);
      rd(`DIPC_POSTCNT_OFS, "no post", 32'h0000_0000);
      u_ext.put(32'h1234_7E38);
      wait_idle;
      rd(`DIPC_POSTCNT_OFS, "post n", 32'h0000_0003);
      repeat (3) rd(`DIPC_DATA_OFS, "post", 32'h1234_7E38);
      bus(1'b0, `DIPC_PRECNT_OFS, 32'h0000_0000);
      chk("pre n", {31'h0, r > 20 && r < 80}, 32'h0000_0001);
      u_ext.put(32'hFFFF_7E39);
      repeat (8) @(posedge hclk);
      bus(1'b1, `DIPC_START_OFS, 32'h0000_0001);
      rd(`DIPC_STATUS_OFS, "rearmed", 32'h0000_0001);
      bus(1'b1, `DIPC_START_OFS, 32'h0000_0002);
      rd(`DIPC_STATUS_OFS, "abort", 32'h0000_0003);
      report_and_stop;
   end
endmodule
`default_nettype wire
